//--- bench/testbench.sv
// Register-level bench for the baud generator and receive status block
`timescale 1ns/1ns
module testbench;
    import ubr_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n, clk_en, psel, penable, pwrite, tx_shift_empty;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, bit_tick, port_enable, rx_enabled, irq, err;
    logic frame_valid, frame_stop_bad;
    logic [8:0] receive_shift_reg;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    logic [7:0] tx_v [4] = '{8'h00, 8'h04, 8'h14, 8'h10};
    logic [7:0] dv [4] = '{8'h02, 8'h00, 8'hFF, 8'h01};
    int pre [4] = '{64, 16, 4, 4};

    always #25 clk_sys = ~clk_sys;

    ubr_top ubr_top_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_valid(frame_valid), .receive_shift_reg(receive_shift_reg),
        .frame_stop_bad(frame_stop_bad), .tx_shift_empty(tx_shift_empty),
        .bit_tick(bit_tick), .port_enable(port_enable), .rx_enabled(rx_enabled), .irq(irq)
    );

    ubr_shift_model ubr_shift_model_i (
        .clk_sys(clk_sys), .frame_valid(frame_valid),
        .receive_shift_reg(receive_shift_reg), .frame_stop_bad(frame_stop_bad)
    );

    task automatic complete_run;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Timeout
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 50000) begin
            failures++;
            complete_run;
        end
    end

    // One APB transfer, idle cycle before setup
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Clock edges until the next tick is seen
    task automatic tick_count(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_sys);
            cnt++;
        end while (bit_tick !== 1'b1);
    endtask

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        tx_shift_empty = 1'b1;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_0000);
        rdchk(UBR_OFS_DIVISOR, 32'h0000_0000);
        chk(32'(err), 32'h0000_0000);
        rdchk(UBR_OFS_TX_STAT, 32'h0000_0002);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        wr(UBR_OFS_DIVISOR, 32'h0000_01FF);
        rdchk(UBR_OFS_DIVISOR, 32'h0000_00FF);
        // Every mode, divisor rewritten mid-count
        for (int i = 0; i < 4; i++) begin
            wr(UBR_OFS_TX_STAT, 32'(tx_v[i]));
            wr(UBR_OFS_DIVISOR, 32'(dv[i]));
            tick_count(n);
            chk(32'(n >= pre[i] * (dv[i] + 1) - 1 && n <= pre[i] * (dv[i] + 1) + 1), 1);
            tick_count(n);
            chk(32'(n), 32'(pre[i] * (dv[i] + 1)));
        end
        // Clock enable low freezes the timer
        tick_count(n);
        clk_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        clk_en <= 1'b1;
        tick_count(n);
        chk(32'(n), 32'(pre[3] * (dv[3] + 1)));
        // Async 9-bit with address match
        wr(UBR_OFS_IRQ_EN, 32'h0000_0007);
        wr(UBR_OFS_TX_STAT, 32'h0000_0004);
        wr(UBR_OFS_RCV_STAT, 32'h0000_00D8);
        ubr_shift_model_i.send(9'h055, 1'b0);
        rdchk(UBR_OFS_IRQ_STAT, 32'h0000_0000);
        ubr_shift_model_i.send(9'h1AA, 1'b0);
        rdchk(UBR_OFS_IRQ_STAT, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        chk(32'(port_enable), 32'h0000_0001);
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_00D9);
        rdchk(UBR_OFS_RCV_BUF, 32'h0000_00AA);
        wr(UBR_OFS_IRQ_CLR, 32'h0000_0007);
        @(negedge clk_sys);
        chk(32'(irq), 32'h0000_0000);
        // No address match, framing error then clean byte
        wr(UBR_OFS_RCV_STAT, 32'h0000_00D0);
        ubr_shift_model_i.send(9'h0A3, 1'b1);
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_00D4);
        rdchk(UBR_OFS_RCV_BUF, 32'h0000_00A3);
        ubr_shift_model_i.send(9'h13C, 1'b0);
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_00D1);
        rdchk(UBR_OFS_RCV_BUF, 32'h0000_003C);
        rdchk(UBR_OFS_IRQ_STAT, 32'h0000_0003);
        wr(UBR_OFS_IRQ_CLR, 32'h0000_0007);
        // Third byte with both slots full is lost
        for (int i = 0; i < 3; i++) begin
            ubr_shift_model_i.send(9'(8'h11 * (i + 1)), 1'b0);
        end
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_00D2);
        rdchk(UBR_OFS_IRQ_STAT, 32'h0000_0005);
        wr(UBR_OFS_IRQ_EN, 32'h0000_0000);
        @(negedge clk_sys);
        chk(32'(irq), 32'h0000_0000);
        wr(UBR_OFS_RCV_STAT, 32'h0000_00C0);
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_00C0);
        wr(UBR_OFS_IRQ_CLR, 32'h0000_0007);
        apb(1'b0, UBR_OFS_RCV_BUF, 32'h0000_0000);
        apb(1'b0, UBR_OFS_RCV_BUF, 32'h0000_0000);
        // Sync: continuous overrides single
        wr(UBR_OFS_TX_STAT, 32'h0000_0010);
        wr(UBR_OFS_RCV_STAT, 32'h0000_00B0);
        ubr_shift_model_i.send(9'h05A, 1'b0);
        ubr_shift_model_i.send(9'h0A5, 1'b0);
        @(negedge clk_sys);
        chk(32'(rx_enabled), 32'h0000_0001);
        apb(1'b0, UBR_OFS_RCV_BUF, 32'h0000_0000);
        apb(1'b0, UBR_OFS_RCV_BUF, 32'h0000_0000);
        wr(UBR_OFS_RCV_STAT, 32'h0000_00A0);
        ubr_shift_model_i.send(9'h0C3, 1'b0);
        @(negedge clk_sys);
        chk(32'(rx_enabled), 32'h0000_0000);
        rdchk(UBR_OFS_RCV_BUF, 32'h0000_00C3);
        rdchk(UBR_OFS_RCV_STAT, 32'h0000_0080);
        complete_run;
    end
endmodule

//--- bench/ubr_shift_model.sv
// Receive shifter stand-in delivering completed frames to the block
`timescale 1ns/1ns
module ubr_shift_model (
    // Clock
    input wire logic clk_sys,
    // Frame out
    output logic frame_valid,
    output logic [8:0] receive_shift_reg,
    output logic frame_stop_bad
);
    initial begin
        frame_valid = 1'b0;
        receive_shift_reg = 9'h000;
        frame_stop_bad = 1'b0;
    end
    // One-cycle frame pulse, lines scrambled outside it
    task automatic send(input logic [8:0] bits, input logic bad);
        @(posedge clk_sys);
        frame_valid <= 1'b1;
        receive_shift_reg <= bits;
        frame_stop_bad <= bad;
        @(posedge clk_sys);
        frame_valid <= 1'b0;
        receive_shift_reg <= ~bits;
        frame_stop_bad <= ~bad;
    endtask
endmodule

//--- src/ubr_baud_timer.sv
// Free-running baud timer with mode prescaler
`timescale 1ns/1ns
module ubr_baud_timer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Configuration
    input wire logic [WIDTH-1:0] divisor,
    input wire logic divisor_wr,
    input wire logic [5:0] prescale,
    // Tick out
    output logic bit_tick
);
    // Divisor register is one byte wide
    if (WIDTH != 8) begin : g_width_check
        $error("baud timer must be 8 bits");
    end
    logic [5:0] pre;
    logic [WIDTH-1:0] count;
    logic tick;
    logic [5:0] next_pre;
    logic [WIDTH-1:0] next_count;
    logic next_tick;
    always_comb begin
        next_pre = pre;
        next_count = count;
        next_tick = 1'b0;
        if (divisor_wr) begin
            next_pre = 6'h00; // RL5
            next_count = '0; // RL5
        end else if (pre >= prescale) begin
            next_pre = 6'h00;
            if (count >= divisor) begin // RL2
                next_count = '0;
                next_tick = 1'b1; // RL3 RL4
            end else begin
                next_count = count + 1'b1; // RL1
            end
        end else begin
            next_pre = pre + 6'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre <= 6'h00;
            count <= '0;
            tick <= 1'b0;
        end else if (clk_en) begin
            pre <= next_pre;
            count <= next_count;
            tick <= next_tick;
        end
    end
    assign bit_tick = tick;
    a_write_clears: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL5
        clk_en && divisor_wr |=> count == '0 && pre == 6'h00)
        else $error("divisor write did not clear timer");
endmodule

//--- src/ubr_pkg.sv
// Constants and types for the baud generator and receive status block
// Operation
// RL1: One 8-bit baud timer shared by modes
// RL2: Timer free-runs, period set by divisor
// RL3: Async rate osc/64(n+1) or osc/16(n+1)
// RL4: Sync ignores high-speed, rate osc/4(n+1)
// RL5: Divisor write clears the baud timer
// RL6: Software should prefer high-speed async setting
// RL7: Address match loads only when bit8 set
// RL8: Framing flag bit 2, refreshed per byte
// RL9: Status bit 0 holds ninth received bit
// RL10: Continuous receive overrides single receive
// RL11: No address match loads every byte
// RL12: Overrun on lost byte, cleared by enable
package ubr_pkg;
    localparam int unsigned UBR_CLK_HZ = 20_000_000;
    // Register byte addresses
    localparam logic [7:0] UBR_OFS_RCV_STAT = 8'h00;
    localparam logic [7:0] UBR_OFS_DIVISOR = 8'h04;
    localparam logic [7:0] UBR_OFS_TX_STAT = 8'h08;
    localparam logic [7:0] UBR_OFS_RCV_BUF = 8'h0C;
    localparam logic [7:0] UBR_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] UBR_OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] UBR_OFS_IRQ_EN = 8'h18;
    // Receive status and control fields
    localparam int UBR_RS_PORT_EN = 7;
    localparam int UBR_RS_NINE = 6;
    localparam int UBR_RS_SINGLE = 5;
    localparam int UBR_RS_CONT = 4;
    localparam int UBR_RS_ADDR = 3;
    localparam int UBR_RS_FRAME_ERR = 2;
    localparam int UBR_RS_OVERRUN = 1;
    localparam int UBR_RS_NINTH = 0;
    // Transmit status and control fields
    localparam int UBR_TS_SYNC = 4;
    localparam int UBR_TS_HSEL = 2;
    localparam int UBR_TS_TRMT = 1;
    // Reset values and transmit write mask
    localparam logic [7:0] UBR_RST_RCV_STAT = 8'h00;
    localparam logic [7:0] UBR_RST_DIVISOR = 8'h00;
    localparam logic [7:0] UBR_RST_TX_STAT = 8'h02;
    localparam logic [7:0] UBR_TX_WMASK = 8'hF5;
    // Prescale counts per timer tick
    localparam logic [5:0] UBR_PRE_ASYNC_LO = 6'h3F;
    localparam logic [5:0] UBR_PRE_ASYNC_HI = 6'h0F;
    localparam logic [5:0] UBR_PRE_SYNC = 6'h03;
    // Interrupt event bits
    localparam int UBR_IRQ_RX = 0;
    localparam int UBR_IRQ_FRAME = 1;
    localparam int UBR_IRQ_OVERRUN = 2;
    localparam int UBR_IRQ_W = 3;
    typedef enum logic [2:0] {
        UBR_RX_IDLE = 3'b001,
        UBR_RX_FULL = 3'b010,
        UBR_RX_HOLD = 3'b100
    } ubr_rx_state_t;
endpackage

//--- src/ubr_rx_status.sv
// Receive buffer load, address filter and error flags
`timescale 1ns/1ns
module ubr_rx_status (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Configuration
    input wire logic nine_bit_receive,
    input wire logic address_match_enable,
    input wire logic sync_mode,
    input wire logic continuous_receive_enable,
    input wire logic single_receive_enable,
    // Received frame from the shifter
    input wire logic frame_valid,
    input wire logic [8:0] receive_shift_reg,
    input wire logic frame_stop_bad,
    // Buffer read by software
    input wire logic buf_read,
    // Status
    output logic [7:0] receive_buffer_reg,
    output logic received_ninth_bit,
    output logic framing_error_flag,
    output logic overrun_error_flag,
    output logic buf_full,
    output logic rx_enabled,
    output logic load_pulse,
    output logic lost_pulse
);
    import ubr_pkg::*;
    ubr_rx_state_t state, next_state;
    logic [7:0] next_buf;
    logic next_ninth, next_frame_err, next_overrun, accept, load;
    always_comb begin
        rx_enabled = sync_mode ? (continuous_receive_enable || single_receive_enable)
                               : continuous_receive_enable; // RL10
        accept = !(nine_bit_receive && address_match_enable && !sync_mode
                   && !receive_shift_reg[8]); // RL7 RL11
        load = frame_valid && rx_enabled && accept && !overrun_error_flag;
        next_state = state;
        next_buf = receive_buffer_reg;
        next_ninth = received_ninth_bit;
        next_frame_err = framing_error_flag;
        next_overrun = overrun_error_flag;
        load_pulse = 1'b0;
        lost_pulse = 1'b0;
        case (state)
            UBR_RX_IDLE: begin
                if (load) begin
                    next_state = UBR_RX_FULL;
                end
            end
            UBR_RX_FULL: begin
                if (buf_read && !load) begin
                    next_state = UBR_RX_IDLE;
                end else if (!buf_read && load) begin
                    next_state = UBR_RX_HOLD;
                end
            end
            UBR_RX_HOLD: begin
                if (buf_read) begin
                    next_state = UBR_RX_FULL;
                end
            end
            default: next_state = UBR_RX_IDLE;
        endcase
        if (load && state == UBR_RX_HOLD && !buf_read) begin
            next_overrun = 1'b1; // RL12
            lost_pulse = 1'b1;
        end else if (load) begin
            next_buf = receive_shift_reg[7:0];
            next_ninth = nine_bit_receive & receive_shift_reg[8]; // RL9
            next_frame_err = frame_stop_bad; // RL8
            load_pulse = 1'b1;
        end
        if (!continuous_receive_enable) begin
            next_overrun = 1'b0; // RL12
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= UBR_RX_IDLE;
            receive_buffer_reg <= 8'h00;
            received_ninth_bit <= 1'b0;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            receive_buffer_reg <= next_buf;
            received_ninth_bit <= next_ninth;
            framing_error_flag <= next_frame_err;
            overrun_error_flag <= next_overrun;
        end
    end
    assign buf_full = state != UBR_RX_IDLE;
    a_addr_filter: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL7
        load_pulse |-> !(nine_bit_receive && address_match_enable && !sync_mode)
        || receive_shift_reg[8])
        else $error("address filter let a data byte through");
    a_nofilter_load: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL11
        clk_en && frame_valid && continuous_receive_enable && !address_match_enable
        && state == UBR_RX_IDLE && !overrun_error_flag
        |=> receive_buffer_reg == $past(receive_shift_reg[7:0]))
        else $error("byte not loaded with filter off");
    a_framing_error_flag_update: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL8
        clk_en && load_pulse |=> framing_error_flag == $past(frame_stop_bad))
        else $error("framing flag not refreshed");
    a_ninth_bit: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL9
        clk_en && load_pulse && nine_bit_receive
        |=> received_ninth_bit == $past(receive_shift_reg[8]))
        else $error("ninth bit not captured");
    a_overrun_set: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL12
        clk_en && lost_pulse && continuous_receive_enable |=> overrun_error_flag)
        else $error("overrun not flagged");
    a_overrun_clr: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL12
        clk_en && !continuous_receive_enable |=> !overrun_error_flag)
        else $error("overrun not cleared");
    a_cont_priority: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL10
        sync_mode && continuous_receive_enable && frame_valid && !overrun_error_flag
        |-> load_pulse || lost_pulse)
        else $error("continuous receive dropped a frame");
endmodule

//--- src/ubr_top.sv
// Baud generator and receive status block with APB registers
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module ubr_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive shifter side
    input wire logic frame_valid,
    input wire logic [8:0] receive_shift_reg,
    input wire logic frame_stop_bad,
    input wire logic tx_shift_empty,
    // Outputs
    output logic bit_tick,
    output logic port_enable,
    output logic rx_enabled,
    output logic irq
);
    import ubr_pkg::*;
    logic [7:0] rcv_ctrl, divisor, tx_ctrl;
    logic [UBR_IRQ_W-1:0] irq_stat, irq_en;
    logic [7:0] next_rcv_ctrl, next_divisor, next_tx_ctrl;
    logic [UBR_IRQ_W-1:0] next_irq_stat, next_irq_en;
    logic [31:0] rd, next_rd;
    logic wr, rdacc, buf_read, divisor_wr;
    logic [5:0] prescale;
    logic [7:0] rbuf;
    logic ninth, frame_err, overrun, full, load_pulse, lost_pulse;
    logic [UBR_IRQ_W-1:0] events;
    logic mapped;

    assign wr = psel && penable && pwrite;
    assign rdacc = psel && penable && !pwrite;
    assign buf_read = rdacc && paddr == UBR_OFS_RCV_BUF;
    assign divisor_wr = wr && paddr == UBR_OFS_DIVISOR;
    assign pready = 1'b1;
    assign mapped = paddr == UBR_OFS_RCV_STAT || paddr == UBR_OFS_DIVISOR
        || paddr == UBR_OFS_TX_STAT || paddr == UBR_OFS_RCV_BUF
        || paddr == UBR_OFS_IRQ_STAT || paddr == UBR_OFS_IRQ_CLR
        || paddr == UBR_OFS_IRQ_EN;
    assign pslverr = psel && penable && !mapped;

    // Mode prescale: sync fixed, async by high-speed select
    always_comb begin
        if (tx_ctrl[UBR_TS_SYNC]) begin
            prescale = UBR_PRE_SYNC; // RL4
        end else if (tx_ctrl[UBR_TS_HSEL]) begin
            prescale = UBR_PRE_ASYNC_HI; // RL3 RL6
        end else begin
            prescale = UBR_PRE_ASYNC_LO; // RL3
        end
    end

    ubr_baud_timer #(.WIDTH(8)) u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .divisor(divisor),
        .divisor_wr(divisor_wr && clk_en),
        .prescale(prescale),
        .bit_tick(bit_tick)
    );

    ubr_rx_status u_rx (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .nine_bit_receive(rcv_ctrl[UBR_RS_NINE]),
        .address_match_enable(rcv_ctrl[UBR_RS_ADDR]),
        .sync_mode(tx_ctrl[UBR_TS_SYNC]),
        .continuous_receive_enable(rcv_ctrl[UBR_RS_CONT]),
        .single_receive_enable(rcv_ctrl[UBR_RS_SINGLE]),
        .frame_valid(frame_valid && rcv_ctrl[UBR_RS_PORT_EN]),
        .receive_shift_reg(receive_shift_reg),
        .frame_stop_bad(frame_stop_bad),
        .buf_read(buf_read),
        .receive_buffer_reg(rbuf),
        .received_ninth_bit(ninth),
        .framing_error_flag(frame_err),
        .overrun_error_flag(overrun),
        .buf_full(full),
        .rx_enabled(rx_enabled),
        .load_pulse(load_pulse),
        .lost_pulse(lost_pulse)
    );

    assign events = {lost_pulse, load_pulse && frame_stop_bad, load_pulse};

    always_comb begin
        next_rcv_ctrl = rcv_ctrl;
        next_divisor = divisor;
        next_tx_ctrl = tx_ctrl;
        next_irq_en = irq_en;
        next_irq_stat = irq_stat;
        if (wr) begin
            case (paddr)
                UBR_OFS_RCV_STAT: next_rcv_ctrl = pwdata[7:0];
                UBR_OFS_DIVISOR: next_divisor = pwdata[7:0]; // RL2
                UBR_OFS_TX_STAT: next_tx_ctrl = pwdata[7:0] & UBR_TX_WMASK;
                UBR_OFS_IRQ_CLR: next_irq_stat = irq_stat & ~pwdata[UBR_IRQ_W-1:0];
                UBR_OFS_IRQ_EN: next_irq_en = pwdata[UBR_IRQ_W-1:0];
                default: next_irq_en = irq_en;
            endcase
        end
        // Single receive self-clears after one byte in sync mode when continuous receive is off
        if (load_pulse && tx_ctrl[UBR_TS_SYNC] && !rcv_ctrl[UBR_RS_CONT]) begin
            next_rcv_ctrl[UBR_RS_SINGLE] = 1'b0;
        end
        next_irq_stat = next_irq_stat | events;
        next_rd = 32'h0000_0000;
        case (paddr)
            UBR_OFS_RCV_STAT: next_rd[7:0] = {rcv_ctrl[7:3], frame_err, overrun, ninth}; // RL8 RL9
            UBR_OFS_DIVISOR: next_rd[7:0] = divisor;
            UBR_OFS_TX_STAT: next_rd[7:0] = {tx_ctrl[7:2], tx_shift_empty, tx_ctrl[0]};
            UBR_OFS_RCV_BUF: next_rd[7:0] = rbuf;
            UBR_OFS_IRQ_STAT: next_rd[UBR_IRQ_W-1:0] = irq_stat;
            UBR_OFS_IRQ_EN: next_rd[UBR_IRQ_W-1:0] = irq_en;
            default: next_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rcv_ctrl <= UBR_RST_RCV_STAT;
            divisor <= UBR_RST_DIVISOR;
            tx_ctrl <= UBR_RST_TX_STAT & UBR_TX_WMASK;
            irq_stat <= '0;
            irq_en <= '0;
            rd <= 32'h0000_0000;
        end else if (clk_en) begin
            rcv_ctrl <= next_rcv_ctrl;
            divisor <= next_divisor;
            tx_ctrl <= next_tx_ctrl;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            rd <= next_rd;
        end
    end

    // Read word captured at the setup edge
    assign prdata = rd;
    assign port_enable = rcv_ctrl[UBR_RS_PORT_EN];
    assign irq = |(irq_stat & irq_en);

    a_div_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL2
        clk_en && divisor_wr |=> divisor == $past(pwdata[7:0]))
        else $error("divisor write lost");
    a_event_wins: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL7
        clk_en && load_pulse |=> irq_stat[UBR_IRQ_RX])
        else $error("receive event lost");
    a_sync_tick: assert property (@(posedge clk_sys) disable iff (!arst_n || !clk_en) // RL4
        bit_tick |=> (!bit_tick) [*3])
        else $error("baud ticks closer than four clocks");
endmodule
